// ===== inc/tpc_defines.vh
// register map, field positions and constants of the timer/pwm block
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

`define TPC_ADDR_W     5
`define TPC_A_SC       5'h00
`define TPC_A_CNTH     5'h01
`define TPC_A_CNTL     5'h02
`define TPC_A_MODH     5'h03
`define TPC_A_MODL     5'h04
`define TPC_CH_BASE    5'h05
`define TPC_CH_STRIDE  5'h03
`define TPC_CH_SC      5'h00
`define TPC_CH_VH      5'h01
`define TPC_CH_VL      5'h02

`define TPC_SC_OVF     7
`define TPC_SC_OVFIE   6
`define TPC_SC_CENTER  5

`define TPC_CH_FLAG    7
`define TPC_CH_IE      6
`define TPC_CH_MSB     5
`define TPC_CH_MSA     4
`define TPC_CH_ELSB    3
`define TPC_CH_ELSA    2

`define TPC_CNT_ZERO   16'h0000
`define TPC_CNT_ONE    16'h0001
`define TPC_CNT_MAX    16'hffff
`define TPC_BYTE_ZERO  8'h00

`endif

// ===== logic/tpc_timer.v
// 16-bit timer with capture, compare and pwm channels behind a byte register port
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.vh"

module tpc_timer #(
  parameter NCH = 2
) (
  input  wire                      clk,      // timer clock
  input  wire                      resetn,   // async reset, active low
  input  wire [`TPC_ADDR_W-1:0]    addr,     // register byte address
  input  wire [7:0]                wrData,   // write data
  input  wire                      wrEn,     // write strobe
  input  wire                      rdEn,     // read strobe
  output reg  [7:0]                rdData,   // read data, cycle after rdEn
  input  wire [NCH-1:0]            chIn,     // channel input pins
  output reg  [NCH-1:0]            chOut,    // channel output pins
  output reg                       irq       // level interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  reg rstMeta_q;
  reg rstSync_q;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  wire rstn = rstSync_q;

  ////////////////////////////////////////////////////////////////////////////
  // main counter and overflow

  reg  [15:0] cnt_q;
  reg         down_q;
  reg  [15:0] mod_q;
  reg  [7:0]  modHi_q;
  reg         ovf_q;
  reg         ovfIe_q;
  reg         center_q;
  reg  [15:0] cntBuf_q;
  reg         cntLat_q;
  reg         cntRdH_q;
  reg         cntRdL_q;

  wire        wrSc   = wrEn && (addr == `TPC_A_SC);
  wire        wrCnt  = wrEn && ((addr == `TPC_A_CNTH) || (addr == `TPC_A_CNTL));
  wire        rdCntH = rdEn && (addr == `TPC_A_CNTH);
  wire        rdCntL = rdEn && (addr == `TPC_A_CNTL);
  wire [15:0] term   = (mod_q == `TPC_CNT_ZERO) ? `TPC_CNT_MAX : mod_q;
  wire        atTerm = (cnt_q == term);
  wire        ovfEvt = atTerm && !(center_q && down_q);
  wire        cntZero = (cnt_q == `TPC_CNT_ZERO);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q  <= `TPC_CNT_ZERO;
      down_q <= 1'b0;
    end
    else if (wrCnt)
    begin
      cnt_q  <= `TPC_CNT_ZERO;
      down_q <= 1'b0;
    end
    else if (center_q)
    begin
      if (!down_q && atTerm)
      begin
        cnt_q  <= cnt_q - `TPC_CNT_ONE;
        down_q <= 1'b1;
      end
      else if (down_q && cntZero)
      begin
        cnt_q  <= cnt_q + `TPC_CNT_ONE;
        down_q <= 1'b0;
      end
      else if (down_q)
        cnt_q <= cnt_q - `TPC_CNT_ONE;
      else
        cnt_q <= cnt_q + `TPC_CNT_ONE;
    end
    else
    begin
      down_q <= 1'b0;
      if (atTerm)
        cnt_q <= `TPC_CNT_ZERO;
      else
        cnt_q <= cnt_q + `TPC_CNT_ONE;
    end
  end

  // status/control and modulus; a set of the flag wins over a clear
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ovf_q    <= 1'b0;
      ovfIe_q  <= 1'b0;
      center_q <= 1'b0;
      mod_q    <= `TPC_CNT_ZERO;
      modHi_q  <= `TPC_BYTE_ZERO;
    end
    else
    begin
      if (ovfEvt && !wrCnt)
        ovf_q <= 1'b1;
      else if (wrSc && !wrData[`TPC_SC_OVF])
        ovf_q <= 1'b0;
      if (wrSc)
      begin
        ovfIe_q  <= wrData[`TPC_SC_OVFIE];
        center_q <= wrData[`TPC_SC_CENTER];
      end
      if (wrEn && (addr == `TPC_A_MODH))
        modHi_q <= wrData;
      if (wrEn && (addr == `TPC_A_MODL))
        mod_q <= {modHi_q, wrData};
    end
  end

  // counter read coherency
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cntBuf_q <= `TPC_CNT_ZERO;
      cntLat_q <= 1'b0;
      cntRdH_q <= 1'b0;
      cntRdL_q <= 1'b0;
    end
    else if (wrCnt)
    begin
      cntLat_q <= 1'b0;
      cntRdH_q <= 1'b0;
      cntRdL_q <= 1'b0;
    end
    else if (rdCntH || rdCntL)
    begin
      if (!cntLat_q)
        cntBuf_q <= cnt_q;
      if ((cntRdH_q || rdCntH) && (cntRdL_q || rdCntL))
      begin
        cntLat_q <= 1'b0;
        cntRdH_q <= 1'b0;
        cntRdL_q <= 1'b0;
      end
      else
      begin
        cntLat_q <= 1'b1;
        cntRdH_q <= cntRdH_q || rdCntH;
        cntRdL_q <= cntRdL_q || rdCntL;
      end
    end
  end

  wire [15:0] cntView = cntLat_q ? cntBuf_q : cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // channels

  wire [8*NCH-1:0] chRd;
  wire [NCH-1:0]   chHit;
  wire [NCH-1:0]   chIrq;
  wire [NCH-1:0]   chOutD;

  genvar n;
  generate
    for (n = 0; n < NCH; n = n + 1)
    begin : gCh
      localparam integer ABASEW = `TPC_CH_BASE + n * `TPC_CH_STRIDE;
      localparam [`TPC_ADDR_W-1:0] ABASE = ABASEW[`TPC_ADDR_W-1:0];
      reg         flag_q;
      reg         ie_q;
      reg         msb_q;
      reg         msa_q;
      reg         elsb_q;
      reg         elsa_q;
      reg  [15:0] val_q;
      reg  [7:0]  bufH_q;
      reg  [7:0]  bufL_q;
      reg         wrH_q;
      reg         wrL_q;
      reg  [15:0] rdBuf_q;
      reg         rdLat_q;
      reg         rdH_q;
      reg         rdL_q;
      reg         inPrev_q;
      reg         out_q;

      wire wrCs  = wrEn && (addr == ABASE + `TPC_CH_SC);
      wire wrVh  = wrEn && (addr == ABASE + `TPC_CH_VH);
      wire wrVl  = wrEn && (addr == ABASE + `TPC_CH_VL);
      wire rdVh  = rdEn && (addr == ABASE + `TPC_CH_VH);
      wire rdVl  = rdEn && (addr == ABASE + `TPC_CH_VL);
      wire isCap = !center_q && !msb_q && !msa_q;
      wire isCmp = !center_q && !msb_q && msa_q;
      wire isPwm = center_q || msb_q;
      wire match = (cnt_q == val_q);
      wire edgeHit = (elsa_q && chIn[n] && !inPrev_q)
                   || (elsb_q && !chIn[n] && inPrev_q);
      wire capEvt  = isCap && edgeHit;
      wire cmpEvt  = isCmp && match && !wrCnt;
      wire pwmEvt  = isPwm && match && !wrCnt;
      wire pairOk  = wrH_q && wrL_q && (!isPwm || cntZero);

      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          flag_q   <= 1'b0;
          ie_q     <= 1'b0;
          msb_q    <= 1'b0;
          msa_q    <= 1'b0;
          elsb_q   <= 1'b0;
          elsa_q   <= 1'b0;
          val_q    <= `TPC_CNT_ZERO;
          bufH_q   <= `TPC_BYTE_ZERO;
          bufL_q   <= `TPC_BYTE_ZERO;
          wrH_q    <= 1'b0;
          wrL_q    <= 1'b0;
          rdBuf_q  <= `TPC_CNT_ZERO;
          rdLat_q  <= 1'b0;
          rdH_q    <= 1'b0;
          rdL_q    <= 1'b0;
          inPrev_q <= 1'b0;
          out_q    <= 1'b0;
        end
        else
        begin
          inPrev_q <= chIn[n];
          if (capEvt || cmpEvt || pwmEvt)
            flag_q <= 1'b1;
          else if (wrCs && !wrData[`TPC_CH_FLAG])
            flag_q <= 1'b0;
          if (wrCs)
          begin
            ie_q   <= wrData[`TPC_CH_IE];
            msb_q  <= wrData[`TPC_CH_MSB];
            msa_q  <= wrData[`TPC_CH_MSA];
            elsb_q <= wrData[`TPC_CH_ELSB];
            elsa_q <= wrData[`TPC_CH_ELSA];
          end
          // value byte buffers and write pairing
          if (wrCs)
          begin
            wrH_q <= 1'b0;
            wrL_q <= 1'b0;
          end
          else if (pairOk && !(wrVh || wrVl))
          begin
            wrH_q <= 1'b0;
            wrL_q <= 1'b0;
          end
          else
          begin
            if (wrVh)
            begin
              bufH_q <= wrData;
              wrH_q  <= 1'b1;
            end
            if (wrVl)
            begin
              bufL_q <= wrData;
              wrL_q  <= 1'b1;
            end
          end
          if (capEvt)
            val_q <= cnt_q;
          else if (pairOk && !(wrVh || wrVl) && !wrCs)
            val_q <= {bufH_q, bufL_q};
          // read coherency of the value
          if (wrCs)
          begin
            rdLat_q <= 1'b0;
            rdH_q   <= 1'b0;
            rdL_q   <= 1'b0;
          end
          else if (rdVh || rdVl)
          begin
            if (!rdLat_q)
              rdBuf_q <= val_q;
            if ((rdH_q || rdVh) && (rdL_q || rdVl))
            begin
              rdLat_q <= 1'b0;
              rdH_q   <= 1'b0;
              rdL_q   <= 1'b0;
            end
            else
            begin
              rdLat_q <= 1'b1;
              rdH_q   <= rdH_q || rdVh;
              rdL_q   <= rdL_q || rdVl;
            end
          end
          // pin drive
          if (cmpEvt)
          begin
            case ({elsb_q, elsa_q})
              2'b01:   out_q <= !out_q;
              2'b10:   out_q <= 1'b0;
              2'b11:   out_q <= 1'b1;
              default: out_q <= out_q;
            endcase
          end
          else if (isPwm)
            out_q <= (cnt_q < val_q) ^ elsa_q;
        end
      end

      wire [15:0] valView = rdLat_q ? rdBuf_q : val_q;

      assign chHit[n]  = (addr == ABASE + `TPC_CH_SC) || (addr == ABASE + `TPC_CH_VH)
                       || (addr == ABASE + `TPC_CH_VL);
      assign chRd[8*n +: 8] =
          (addr == ABASE + `TPC_CH_SC) ? {flag_q, ie_q, msb_q, msa_q, elsb_q, elsa_q, 2'b00} :
          (addr == ABASE + `TPC_CH_VH) ? valView[15:8] :
          (addr == ABASE + `TPC_CH_VL) ? valView[7:0] : `TPC_BYTE_ZERO;
      assign chIrq[n]  = flag_q && ie_q;
      assign chOutD[n] = out_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read mux and outputs

  reg [7:0] rdMux;
  integer   k;

  always @*
  begin
    rdMux = `TPC_BYTE_ZERO;
    case (addr)
      `TPC_A_SC:   rdMux = {ovf_q, ovfIe_q, center_q, 5'b00000};
      `TPC_A_CNTH: rdMux = cntView[15:8];
      `TPC_A_CNTL: rdMux = cntView[7:0];
      `TPC_A_MODH: rdMux = mod_q[15:8];
      `TPC_A_MODL: rdMux = mod_q[7:0];
      default:
      begin
        for (k = 0; k < NCH; k = k + 1)
          if (chHit[k])
            rdMux = chRd[8*k +: 8];
      end
    endcase
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdData <= `TPC_BYTE_ZERO;
      chOut  <= {NCH{1'b0}};
      irq    <= 1'b0;
    end
    else
    begin
      rdData <= rdEn ? rdMux : `TPC_BYTE_ZERO;
      chOut  <= chOutD;
      irq    <= (ovf_q && ovfIe_q) || (|chIrq);
    end
  end

endmodule // tpc_timer

`default_nettype wire

// ===== tb/tpc_pin_model.sv
// event source that drives the channel input pins
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model #(
  parameter NCH = 2
) (
  input  wire logic           clk,    // timer clock
  input  wire logic [NCH-1:0] flip,   // toggle request per pin
  output var  logic [NCH-1:0] pinLvl  // pin levels
);
  initial pinLvl = '0;
  // a pin moves one clock after its request
  always @(posedge clk)
    pinLvl <= pinLvl ^ flip;
endmodule // tpc_pin_model
`default_nettype wire

// ===== tb/tpc_timer_monitor.sv
// port assertions for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.vh"
module tpc_timer_monitor #(
  parameter NCH = 2
) (
  input wire logic           clk,    // timer clock
  input wire logic           resetn, // async reset
  input wire logic [4:0]     addr,   // byte address
  input wire logic [7:0]     wrData, // write data
  input wire logic           wrEn,   // write strobe
  input wire logic           rdEn,   // read strobe
  input wire logic [7:0]     rdData, // read data
  input wire logic [NCH-1:0] chIn,   // channel inputs
  input wire logic [NCH-1:0] chOut,  // channel outputs
  input wire logic           irq     // interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [NCH:0] irqEn_q;
  wire wrLo = wrEn && addr == `TPC_A_CNTL;
  wire wrHi = wrEn && addr == `TPC_A_CNTH;
  wire rdLo = rdEn && addr == `TPC_A_CNTL;
  wire rdHi = rdEn && addr == `TPC_A_CNTH;
  // shadow of the interrupt enables
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      irqEn_q <= '0;
    else if (wrEn)
      for (int n = 0; n <= NCH; n++)
        if (addr == 5'(n == 0 ? `TPC_A_SC : `TPC_CH_BASE + 3 * n - 3))
          irqEn_q[n] <= wrData[6];
  ////////////////////////////////////////
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn [*2] |-> !irq && chOut == '0 && rdData == 8'h00) else $error("output in reset");
  read_idle_a: assert property (!$past(rdEn) |-> rdData == 8'h00)
    else $error("read data without read");
  cnt_clear_lo_a: assert property (wrLo ##2 rdLo |=> rdData == 8'h01)
    else $error("counter not cleared");
  cnt_clear_hi_a: assert property (wrHi ##2 rdHi |=> rdData == 8'h00)
    else $error("counter high not cleared");
  irq_gate_a: assert property (irq |-> $past(|irqEn_q))
    else $error("irq without enable");
  irq_off_a: assert property (
    wrEn && addr == `TPC_A_SC && !wrData[6] && irqEn_q[NCH:1] == '0 |-> ##2 !irq)
    else $error("irq stays after disable");
  irq_hold_a: assert property (irq && !wrEn && !$past(wrEn) |-> ##2 irq)
    else $error("flag cleared by itself");
  ctrl_low_bits_a: assert property (rdEn && addr == `TPC_CH_BASE |=> rdData[1:0] == 2'b00)
    else $error("control spare bits set");
  cover property (irq);
  cover property (wrLo ##2 rdLo);
  cover property ($rose(chOut[0]));
endmodule // tpc_timer_monitor
bind tpc_timer tpc_timer_monitor #(.NCH(NCH)) u_mon (.clk(clk), .resetn(resetn), .addr(addr),
  .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .chIn(chIn), .chOut(chOut),
  .irq(irq));
`default_nettype wire

// ===== tb/timer_pwm_capture_compare_tb.sv
// self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.vh"
module timer_pwm_capture_compare_tb;
  logic        clk = 0, resetn = 0, wrEn = 0, rdEn = 0;
  logic [4:0]  addr = '0;
  logic [7:0]  wrData = '0, rdData, d;
  logic [1:0]  chIn, chOut, flip = '0;
  logic        irq;
  logic [15:0] v, h;
  int          cyc = 0, wrCyc = 0, n_mismatch = 0, compares = 0, seed = 12, m, k, c;
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tpc_timer #(.NCH(2)) u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .chIn(chIn), .chOut(chOut), .irq(irq));
  tpc_pin_model #(.NCH(2)) u_pins (.clk(clk), .flip(flip), .pinLvl(chIn));
  ////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wrData <= x;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    if (a == `TPC_A_CNTL || a == `TPC_A_CNTH) wrCyc = cyc;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    k = cyc - wrCyc - 1;
    #1;
    x = rdData;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] cntAt(input int t, input int md, input bit ctr);
    if (ctr) t = t % (2 * md);
    if (ctr) return 16'(t <= md ? t : 2 * md - t);
    return 16'(md == 0 ? t : t % (md + 1));
  endfunction
  // high byte live, low byte after a random pause
  task automatic rc(input int md, input bit ctr);
    logic [15:0] e;
    rd(`TPC_A_CNTH, d);
    e = cntAt(k, md, ctr);
    chk("cnt hi", 16'(e[15:8]), 16'(d));
    repeat ($unsigned($random(seed)) % 300) @(posedge clk);
    rd(`TPC_A_CNTL, d);
    chk("cnt lo", 16'(e[7:0]), 16'(d));
  endtask
  task automatic flipPin();
    @(posedge clk);
    flip <= 2'b10;
    c = cyc - wrCyc;
    @(posedge clk);
    flip <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #380000;
    n_mismatch++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    wr(`TPC_A_CNTL, 8'h5a);
    rd(`TPC_A_CNTL, d);
    chk("cnt clr", 16'h0001, 16'(d));
    rd(`TPC_A_CNTH, d);
    chk("cnt pair", 16'h0000, 16'(d));
    wr(`TPC_A_CNTH, 8'ha5);
    repeat (4) rc(0, 0);
    wr(`TPC_A_SC, 8'h00);
    repeat (65540) @(posedge clk);
    rd(`TPC_A_SC, d);
    chk("wrap flag", 16'h0080, 16'(d));
    rc(0, 0);
    m = 20 + $unsigned($random(seed)) % 40;
    wr(`TPC_A_MODH, 8'h00);
    wr(`TPC_A_MODL, 8'(m));
    wr(`TPC_A_CNTL, 8'h00);
    wr(`TPC_A_SC, 8'h00);
    rd(`TPC_A_SC, d);
    chk("mod flag", 16'h0000, 16'(d));
    repeat (4) rc(m, 0);
    repeat (64) @(posedge clk);
    rd(`TPC_A_SC, d);
    chk("mod flag", 16'h0080, 16'(d));
    wr(`TPC_A_SC, 8'hc0);
    repeat (2) @(posedge clk);
    chk("irq on", 16'h0001, 16'(irq));
    wr(`TPC_A_SC, 8'h80);
    repeat (2) @(posedge clk);
    chk("irq off", 16'h0000, 16'(irq));
    wr(`TPC_A_CNTL, 8'h00);
    wr(`TPC_A_SC, 8'h20);
    rd(`TPC_A_SC, d);
    chk("turn flag", 16'h0020, 16'(d));
    repeat (4) rc(m, 1);
    repeat (64) @(posedge clk);
    rd(`TPC_A_SC, d);
    chk("turn flag", 16'h00a0, 16'(d));
    wr(`TPC_A_SC, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(`TPC_A_CNTL, 8'h00);
      wr(5'h05, 8'h50 | 8'((3 - i) << 2));
      wr(5'h06, 8'h00);
      wr(5'h07, 8'd10);
      repeat (12) @(posedge clk);
      chk("cmp pin", 16'(i != 1), 16'(chOut[0]));
      chk("cmp irq", 16'h0001, 16'(irq));
      rd(5'h05, d);
      chk("cmp flag", 16'(8'hd0 | 8'((3 - i) << 2)), 16'(d));
    end
    for (int e = 1; e < 4; e++)
    begin
      wr(5'h08, 8'(e << 2));
      wr(`TPC_A_CNTL, 8'h00);
      flipPin();
      rd(5'h08, d);
      chk("cap rise", 16'(e & 1), 16'(d[7]));
      rd(5'h09, d);
      v[15:8] = d;
      rd(5'h0a, d);
      v[7:0] = d;
      if (e & 1) chk("cap val", 16'(c + 1), v);
      wr(5'h08, 8'(e << 2));
      flipPin();
      rd(5'h08, d);
      chk("cap fall", 16'(e >> 1), 16'(d[7]));
    end
    wr(`TPC_A_MODL, 8'd19);
    wr(`TPC_A_CNTL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      m = i == 0 ? 0 : i == 1 ? 7 : i == 2 ? 20 : 5;
      wr(5'h05, 8'h20 | 8'((i & 1) << 2));
      wr(5'h06, 8'h00);
      wr(5'h07, 8'(m));
      repeat (50) @(posedge clk);
      h = 0;
      repeat (40)
      begin
        @(posedge clk);
        #1;
        h += chOut[0];
      end
      k = (i & 1) ? 40 - 2 * m : 2 * m;
      chk("pwm high", 16'(k), h);
    end
    // mid-run reset with flags set, then look at cleared state
    @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TPC_A_CNTL, d);
    chk("rst cnt", 16'h0002, 16'(d));
    rd(`TPC_A_SC, d);
    chk("rst sc", 16'h0000, 16'(d));
    rd(5'h05, d);
    chk("rst ch", 16'h0000, 16'(d));
    report_and_stop();
  end
endmodule // timer_pwm_capture_compare_tb
`default_nettype wire
